// file: hw/tci_pkg.sv
// Package for the timer/counter with interrupt entry and return stack.
// Assumes one instruction-cycle clock; sequencer drives one-cycle strobes.
package tci_pkg;
    // -----------------------------------------------------------------
    // Widths and timing
    // -----------------------------------------------------------------
    localparam int PRE_W = 6;
    localparam int CNT_W = 4;
    localparam int PAGE_W = 5;
    localparam int ADDR_W = 6;
    localparam int PC_W = PAGE_W + ADDR_W;
    localparam int STACK_DEPTH = 4;
    localparam int CLK_HZ = 10_000_000;
    localparam int PIN_MIN_NS = 200;
    localparam int PIN_MIN_CYC = (PIN_MIN_NS * (CLK_HZ / 1_000_000)
        + 999) / 1000;
    localparam logic [PRE_W-1:0] PRE_ZERO = 6'h00;
    localparam logic [PRE_W-1:0] PRE_MAX = 6'h3F;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [PAGE_W-1:0] CALL_PAGE = 5'h00;
    // -----------------------------------------------------------------
    // Vectors and reset values
    // -----------------------------------------------------------------
    localparam logic [PC_W-1:0] INPUT_VEC = 11'h07F;
    localparam logic [PC_W-1:0] TIMER_VEC = 11'h03F;
    localparam logic [PC_W-1:0] PC_ZERO = 11'h000;
    localparam logic RST_MASK = 1'b1;
    localparam logic RST_FLAG = 1'b0;

    typedef enum logic {
        TCI_SRC_TIMER,
        TCI_SRC_PIN
    } tci_src_t;

    // Sequencer strobes, one cycle each
    typedef struct packed {
        logic load_counter_from_acc;
        logic load_counter_immediate;
        logic [CNT_W-1:0] load_value;
        logic set_mask;
        logic clear_mask;
        logic set_source;
        logic clear_source;
        logic call_page_zero;
        logic [ADDR_W-1:0] call_operand;
        logic return_from_call;
        logic return_from_irq;
        logic [PC_W-1:0] next_pc;
        logic [PC_W-1:0] current_pc;
        logic status_in;
        logic input_irq_event;
    } tci_cmd_t;

    typedef struct packed {
        logic [PC_W-1:0] pc_load_value;
        logic pc_load;
        logic status_set;
        logic irq_taken;
        logic test_timer_mask;
        logic [CNT_W-1:0] count;
        logic overflow;
        logic timer_irq_pending;
        logic input_irq_pending;
        logic irq_enable;
        tci_src_t count_source_select;
    } tci_rsp_t;

    typedef struct packed {
        logic [PRE_W-1:0] prescale;
        logic [CNT_W-1:0] count;
        logic [2:0] pin_sync;
        logic pin_level;
        logic mask;
        tci_src_t source;
        logic timer_pending;
        logic input_pending;
        logic irq_enable;
        logic overflow;
        logic irq_taken;
        logic pc_load;
        logic status_set;
        logic [PC_W-1:0] pc_value;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    } tci_state_t;
endpackage

// file: hw/tci_timer_irq.sv
// Timer/counter, interrupt acceptance and four-level return stack.
// Assumes sequencer strobes are single-cycle and on mclk; the count pin
// is asynchronous and is synchronised here.
module tci_timer_irq (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Sequencer side
    input tci_pkg::tci_cmd_t cmd,
    output tci_pkg::tci_rsp_t rsp,
    // External pins
    input wire logic ext_irq_pin_one,
    input wire logic ext_irq_pin_zero
);
    import tci_pkg::*;

    tci_state_t st;
    tci_state_t next_st;

    function automatic logic [STACK_DEPTH-1:0][PC_W-1:0] push_stack(
        input logic [STACK_DEPTH-1:0][PC_W-1:0] s,
        input logic [PC_W-1:0] v);
        push_stack = {s[STACK_DEPTH-2:0], v};
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic pre_tick;
    logic pin_rise;
    logic cnt_tick;
    logic cnt_load;
    logic wrap;
    logic take_input;
    logic take_timer;
    logic timer_req;
    logic call_go;

    always_comb begin
        next_st = st;
        pre_tick = (st.prescale == PRE_MAX);
        // Pin level changes once second and third stages agree
        pin_rise = (st.pin_sync[2] == st.pin_sync[1]) && st.pin_sync[1]
            && !st.pin_level;
        cnt_tick = (st.source == TCI_SRC_PIN) ? pin_rise : pre_tick;
        cnt_load = cmd.load_counter_from_acc || cmd.load_counter_immediate;
        wrap = cnt_tick && !cnt_load && (st.count == CNT_MAX);
        timer_req = wrap && !st.mask;
        call_go = cmd.call_page_zero && cmd.status_in;
        take_input = st.irq_enable && st.input_pending;
        take_timer = st.irq_enable && !st.input_pending
            && st.timer_pending;

        next_st.pin_sync = {st.pin_sync[1:0], ext_irq_pin_one};
        if (st.pin_sync[2] == st.pin_sync[1]) begin
            next_st.pin_level = st.pin_sync[1];
        end

        // Free running, cleared only by a counter load
        next_st.prescale = st.prescale + 6'h01;
        if (cnt_load) begin
            next_st.prescale = PRE_ZERO;
            next_st.count = cmd.load_value;
        end else if (cnt_tick) begin
            next_st.count = st.count + 4'h1;
        end
        next_st.overflow = wrap;

        if (cmd.set_source) begin
            next_st.source = TCI_SRC_PIN;
        end else if (cmd.clear_source) begin
            next_st.source = TCI_SRC_TIMER;
        end

        if (cmd.set_mask) begin
            next_st.mask = 1'b1;
        end else if (cmd.clear_mask) begin
            next_st.mask = 1'b0;
        end
        if (timer_req) begin
            next_st.mask = 1'b1;
        end

        next_st.irq_taken = 1'b0;
        next_st.pc_load = 1'b0;
        next_st.status_set = 1'b0;
        if (take_input || take_timer) begin
            next_st.stack = push_stack(st.stack, cmd.current_pc);
            next_st.pc_value = take_input ? INPUT_VEC : TIMER_VEC;
            next_st.pc_load = 1'b1;
            next_st.irq_taken = 1'b1;
            next_st.irq_enable = 1'b0;
            if (take_input) begin
                next_st.input_pending = 1'b0;
            end else begin
                next_st.timer_pending = 1'b0;
            end
        end else if (call_go) begin
            next_st.stack = push_stack(st.stack, cmd.next_pc);
            next_st.pc_value = {CALL_PAGE, cmd.call_operand};
            next_st.pc_load = 1'b1;
        end else if (cmd.call_page_zero) begin
            next_st.status_set = 1'b1;
        end else if (cmd.return_from_call || cmd.return_from_irq) begin
            next_st.pc_value = st.stack[0];
            next_st.stack = {st.stack[0], st.stack[STACK_DEPTH-1:1]};
            next_st.pc_load = 1'b1;
            if (cmd.return_from_irq) begin
                next_st.irq_enable = 1'b1;
            end
        end
        // New requests win over the clear of an accepted one
        if (timer_req) begin
            next_st.timer_pending = 1'b1;
        end
        if (cmd.input_irq_event) begin
            next_st.input_pending = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st.prescale <= PRE_ZERO;
            st.count <= CNT_ZERO;
            st.pin_sync <= 3'h0;
            st.pin_level <= 1'b0;
            st.mask <= RST_MASK;
            st.source <= TCI_SRC_TIMER;
            st.timer_pending <= RST_FLAG;
            st.input_pending <= RST_FLAG;
            st.irq_enable <= RST_FLAG;
            st.overflow <= 1'b0;
            st.irq_taken <= 1'b0;
            st.pc_load <= 1'b0;
            st.status_set <= 1'b0;
            st.pc_value <= PC_ZERO;
            st.stack <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        rsp.pc_load_value = st.pc_value;
        rsp.pc_load = st.pc_load;
        rsp.status_set = st.status_set;
        rsp.irq_taken = st.irq_taken;
        rsp.test_timer_mask = st.mask;
        rsp.count = st.count;
        rsp.overflow = st.overflow;
        rsp.timer_irq_pending = st.timer_pending;
        rsp.input_irq_pending = st.input_pending;
        rsp.irq_enable = st.irq_enable;
        rsp.count_source_select = st.source;
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------------------------
    // Prescaler and counter
    // ---------------------------------------------------------------
    prescale_wrap_a: assert property (
        st.prescale == PRE_MAX && !cnt_load |=> st.prescale == PRE_ZERO)
        else $error("prescaler did not wrap");

    load_clear_a: assert property (
        cnt_load |=> st.prescale == PRE_ZERO
        && st.count == $past(cmd.load_value))
        else $error("load did not clear prescaler");

    prescale_run_a: assert property (
        !cnt_load |=> st.prescale == $past(st.prescale) + 6'h01)
        else $error("prescaler stalled");

    count_step_a: assert property (
        cnt_tick && !cnt_load |=> st.count == $past(st.count) + 4'h1)
        else $error("counter did not step by one");

    load_wins_a: assert property (
        cnt_load && cnt_tick |=> st.count == $past(cmd.load_value)
        && !st.overflow)
        else $error("increment beat a load");

    wrap_pulse_a: assert property (
        wrap |=> st.overflow && st.count == CNT_ZERO)
        else $error("wrap missing overflow");

    overflow_once_a: assert property (
        st.overflow |=> !st.overflow)
        else $error("overflow pulse too long");

    // ---------------------------------------------------------------
    // Count source
    // ---------------------------------------------------------------
    src_set_a: assert property (
        cmd.set_source |=> st.source == TCI_SRC_PIN)
        else $error("source not set to pin");

    src_clear_a: assert property (
        cmd.clear_source && !cmd.set_source
        |=> st.source == TCI_SRC_TIMER)
        else $error("source not set to prescaler");

    timer_src_a: assert property (
        st.source == TCI_SRC_TIMER && !cnt_load && st.prescale != PRE_MAX
        |=> st.count == $past(st.count))
        else $error("counter moved without tick");

    pin_src_a: assert property (
        st.source == TCI_SRC_PIN && !cnt_load && !pin_rise
        |=> st.count == $past(st.count))
        else $error("counter moved without pin edge");

    pin_once_a: assert property (
        pin_rise |=> !pin_rise)
        else $error("one pin edge counted twice");

    // ---------------------------------------------------------------
    // Mask and requests
    // ---------------------------------------------------------------
    mask_set_a: assert property (
        cmd.set_mask |=> st.mask)
        else $error("mask not set");

    mask_clear_a: assert property (
        cmd.clear_mask && !cmd.set_mask && !timer_req |=> !st.mask)
        else $error("mask not cleared");

    mask_req_a: assert property (
        wrap && !st.mask && !st.irq_enable
        |=> st.mask && st.timer_pending)
        else $error("unmasked overflow lost");

    masked_quiet_a: assert property (
        wrap && st.mask && !take_timer
        |=> st.timer_pending == $past(st.timer_pending))
        else $error("masked overflow raised a request");

    timer_hold_a: assert property (
        st.timer_pending && !take_timer |=> st.timer_pending)
        else $error("timer request dropped");

    input_latch_a: assert property (
        cmd.input_irq_event |=> st.input_pending)
        else $error("input request not latched");

    hold_pending_a: assert property (
        !st.irq_enable && st.input_pending |=> st.input_pending)
        else $error("input request lost while disabled");

    reset_state_a: assert property (
        disable iff (1'b0) !rst_n |=> st.mask && !st.timer_pending
        && !st.input_pending && !st.irq_enable
        && st.source == TCI_SRC_TIMER)
        else $error("reset values wrong");

    // ---------------------------------------------------------------
    // Interrupt entry and return
    // ---------------------------------------------------------------
    input_first_a: assert property (
        st.irq_enable && st.input_pending && st.timer_pending
        |=> st.timer_pending && st.pc_value == INPUT_VEC)
        else $error("priority wrong");

    input_clear_a: assert property (
        take_input && !cmd.input_irq_event
        |=> !st.input_pending && !st.irq_enable)
        else $error("accepted request not cleared");

    timer_vec_a: assert property (
        take_timer |=> st.pc_value == TIMER_VEC && st.pc_load
        && st.irq_taken)
        else $error("timer vector wrong");

    take_push_a: assert property (
        take_input || take_timer |=> st.stack[0] == $past(cmd.current_pc)
        && st.stack[1] == $past(st.stack[0]) && !st.irq_enable)
        else $error("interrupt stacking wrong");

    status_keep_a: assert property (
        take_input || take_timer |=> !st.status_set)
        else $error("interrupt touched status");

    reti_en_a: assert property (
        cmd.return_from_irq && !take_input && !take_timer && !call_go
        && !cmd.call_page_zero
        |=> st.irq_enable && st.pc_value == $past(st.stack[0]))
        else $error("return did not enable");

    // ---------------------------------------------------------------
    // Stack and page-zero call
    // ---------------------------------------------------------------
    call_push_a: assert property (
        call_go && !take_input && !take_timer
        |=> st.pc_load && !st.status_set && st.stack[0] == $past(cmd.next_pc)
        && st.stack[3] == $past(st.stack[2])
        && st.pc_value == {CALL_PAGE, $past(cmd.call_operand)})
        else $error("page-zero call wrong");

    stack_pop_a: assert property (
        cmd.return_from_call && !cmd.return_from_irq && !take_input
        && !take_timer && !cmd.call_page_zero
        |=> st.pc_value == $past(st.stack[0])
        && st.stack[0] == $past(st.stack[1])
        && st.irq_enable == $past(st.irq_enable))
        else $error("return pop wrong");

    call_skip_a: assert property (
        cmd.call_page_zero && !cmd.status_in && !take_input && !take_timer
        |=> st.status_set && !st.pc_load)
        else $error("skipped call misbehaved");

    timer_irq_c: cover property (take_timer ##1 st.irq_taken);
    call_c: cover property (call_go ##1 st.pc_load);
    pin_count_c: cover property (st.source == TCI_SRC_PIN && wrap);
    both_pend_c: cover property (st.input_pending && st.timer_pending
        && st.irq_enable);
    load_tick_c: cover property (cnt_load && cnt_tick);
endmodule

// file: sim/tb.sv
// Self-checking bench for the timer, interrupt entry and return stack.
// Assumes the sequencer strobes are one cycle and answers one cycle later.
`define CHK(a, b) \
    begin \
        num_checks++; \
        if ((a) !== (b)) begin \
            mismatches++; \
            $display("unexpected at %0t: %h vs %h", $time, a, b); \
        end \
    end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tci_pkg::*;

    logic mclk;
    logic rst_n;
    logic pin;
    logic pin_zero;
    tci_cmd_t cmd;
    tci_cmd_t base;
    tci_cmd_t c;
    tci_rsp_t rsp;
    int mismatches;
    int num_checks;
    int m;
    int n;
    int q[$];

    tci_timer_irq dut (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
        .ext_irq_pin_one(pin), .ext_irq_pin_zero(pin_zero));
    tci_pin_model far (.mclk(mclk), .pin(pin));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One-cycle strobe, then back to idle
    task automatic issue(input tci_cmd_t s);
        @(negedge mclk) cmd = s;
        @(negedge mclk) cmd = base;
        pin_zero = 1'($urandom);
    endtask

    // Bounded wait for overflow (sel 0) or interrupt accept (sel 1)
    task automatic wait_hi(input int sel, output int cnt);
        cnt = 1;
        while (cnt < 1100) begin
            if ((sel == 0 ? rsp.overflow : rsp.irq_taken) === 1'b1) return;
            @(negedge mclk);
            cnt++;
        end
        mismatches++;
        wrap_up();
    endtask

    initial begin
        base = '0;
        base.current_pc = 11'h2a5;
        base.status_in = 1'b1;
        cmd = base;
        rst_n = 1'b0;
        pin_zero = 1'b0;
        mismatches = 0;
        num_checks = 0;
        void'($urandom(31));
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        `CHK(rsp.test_timer_mask, RST_MASK)
        `CHK({rsp.timer_irq_pending, rsp.input_irq_pending}, 2'h0)
        `CHK(rsp.irq_enable, 1'b0)
        `CHK(rsp.count_source_select, TCI_SRC_TIMER)
        $display("test reset done");
        // ------------------------------------------------------------
        // Timer mode: masked, then unmasked overflow
        // ------------------------------------------------------------
        c = base;
        c.load_counter_from_acc = 1'b1;
        c.load_value = 4'hf;
        issue(c);
        wait_hi(0, m);
        `CHK(m, 65)
        `CHK(rsp.count, CNT_ZERO)
        @(negedge mclk);
        `CHK(rsp.timer_irq_pending, 1'b0)
        c = base;
        c.clear_mask = 1'b1;
        issue(c);
        `CHK(rsp.test_timer_mask, 1'b0)
        n = 12 + $urandom % 4;
        c = base;
        c.load_counter_immediate = 1'b1;
        c.load_value = 4'(n);
        issue(c);
        `CHK(rsp.count, 4'(n))
        wait_hi(0, m);
        `CHK(m, (16 - n) * 64 + 1)
        @(negedge mclk);
        `CHK({rsp.timer_irq_pending, rsp.test_timer_mask}, 2'h3)
        // Second load lands on the prescaler tick; the load must win
        c = base;
        c.load_counter_immediate = 1'b1;
        c.load_value = 4'($urandom);
        issue(c);
        repeat (62) @(negedge mclk);
        c.load_value = c.load_value ^ 4'h5;
        issue(c);
        `CHK(rsp.count, c.load_value)
        $display("test timer done");
        // Input and timer both pending, taken one at a time
        c = base;
        c.input_irq_event = 1'b1;
        issue(c);
        `CHK(rsp.input_irq_pending, 1'b1)
        c = base;
        c.return_from_irq = 1'b1;
        for (int i = 0; i < 2; i++) begin
            issue(c);
            `CHK(rsp.irq_enable, 1'b1)
            if (q.size() > 0) begin
                `CHK(rsp.pc_load_value, 11'(q.pop_front()))
            end
            wait_hi(1, m);
            `CHK(m, 2)
            `CHK(rsp.pc_load_value, i == 0 ? INPUT_VEC : TIMER_VEC)
            `CHK({rsp.irq_enable, rsp.status_set}, 2'h0)
            `CHK(rsp.timer_irq_pending, 1'(i == 0))
            q.push_front(int'(base.current_pc));
        end
        $display("test interrupt done");
        // Calls fill the stack past its depth, then unwind
        for (int i = 0; i < 6; i++) begin
            c = base;
            c.call_page_zero = 1'b1;
            c.next_pc = 11'($urandom);
            c.call_operand = 6'($urandom);
            c.status_in = 1'(i != 5);
            issue(c);
            if (i == 5) `CHK({rsp.status_set, rsp.pc_load}, 2'h2)
            else begin
                `CHK(rsp.pc_load_value, {CALL_PAGE, c.call_operand})
                `CHK(rsp.pc_load, 1'b1)
                q.push_front(int'(c.next_pc));
                if (q.size() > 4) void'(q.pop_back());
            end
        end
        c = base;
        c.return_from_call = 1'b1;
        repeat (4) begin
            issue(c);
            `CHK(rsp.pc_load_value, 11'(q.pop_front()))
        end
        $display("test stack done");
        // Counter mode: prescaler ignored, pin edges counted
        c = base;
        c.set_source = 1'b1;
        issue(c);
        `CHK(rsp.count_source_select, TCI_SRC_PIN)
        c = base;
        c.load_counter_immediate = 1'b1;
        c.load_value = 4'he;
        issue(c);
        repeat (70) @(negedge mclk);
        `CHK(rsp.count, 4'he)
        far.pulses(3);
        repeat (6) @(negedge mclk);
        `CHK(rsp.count, 4'h1)
        $display("test counter done");
        wrap_up();
    end
endmodule

// file: sim/tci_pin_model.sv
// Far-side model: the external source that drives the count pin.
// Assumes the bench calls pulses() from its main sequence on mclk.
module tci_pin_model (
    // Clock
    input wire logic mclk,
    // Count pin, idle low between pulses
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pin = 1'b0;

    // Each level is held for at least two instruction cycles
    task automatic pulses(input int n);
        repeat (n) begin
            @(negedge mclk) pin = 1'b1;
            repeat (tci_pkg::PIN_MIN_CYC) @(negedge mclk);
            pin = 1'b0;
            repeat (tci_pkg::PIN_MIN_CYC) @(negedge mclk);
        end
    endtask
endmodule
